/* File: hdl/sar_defines.svh */
// Register offsets, field positions, reset values and timing counts of the stream attribute registers.
// Assumes a 12-bit APB byte address and 32-bit data words.
// What this block does
// - The low byte of attribute register A holds sync clock, component format, range, colorimetry and bit depth.
// - Audio-only bit 10 of register A, zero after reset, inserts info and timestamp packets every 512 BS symbols.
// - Register A bit 8 overrides audio clocking, bit 9 picks sync or async audio, bit 11 is audio ratio control.
// - Register B bit 0 marks an even interlaced vertical total, bits 2..1 are stereo, bits 6..3 are reserved.
// - In asynchronous clocking the block computes M itself and never writes it back into the M register.
// - In asynchronous clocking the N value used inside is never copied into the N register.
// - The transfer unit size register resets to 64.
// - Bit 0 of the transfer unit size ignores writes, so the size is always even.
`ifndef SAR_DEFINES_SVH
`define SAR_DEFINES_SVH

`define SAR_ADDR_W        12
`define SAR_OFF_MISC_A    12'h1a4
`define SAR_OFF_MISC_B    12'h1a8
`define SAR_OFF_MVID      12'h1ac
`define SAR_OFF_TU        12'h1b0
`define SAR_OFF_NVID      12'h1b4
`define SAR_OFF_STATUS    12'h1e0

`define SAR_MA_SYNC       0
`define SAR_MA_FMT_LO     1
`define SAR_MA_FMT_HI     2
`define SAR_MA_RANGE      3
`define SAR_MA_COLOR      4
`define SAR_MA_DEPTH_LO   5
`define SAR_MA_DEPTH_HI   7
`define SAR_MA_AUD_OVR    8
`define SAR_MA_AUD_SYNC   9
`define SAR_MA_AUD_ONLY   10
`define SAR_MA_AUD_RATIO  11
`define SAR_MB_VT_EVEN    0
`define SAR_MB_STEREO_LO  1
`define SAR_MB_STEREO_HI  2
`define SAR_MB_RSVD_MASK  8'h78

`define SAR_MISC_A_RST    12'h000
`define SAR_MISC_B_RST    8'h00
`define SAR_RATIO_RST     24'h000000
`define SAR_TU_RST        7'h40

`define SAR_BS_CNT_LAST   9'h1ff
`define SAR_ASYNC_NVID    24'h008000

`endif

/* File: hdl/sar_pkg.sv */
// Types of the stream attribute registers: register select and the state records of both modules.
// Assumes sar_defines.svh is on the include path.
package sar_pkg;

    typedef enum logic [2:0]
    {
        SAR_SEL_NONE   = 3'b000,
        SAR_SEL_MISC_A = 3'b001,
        SAR_SEL_MISC_B = 3'b010,
        SAR_SEL_MVID   = 3'b011,
        SAR_SEL_TU     = 3'b100,
        SAR_SEL_NVID   = 3'b101,
        SAR_SEL_STATUS = 3'b110
    } sar_sel_t;

    typedef struct packed
    {
        logic [11:0] misc_a;
        logic [7:0]  misc_b;
        logic [23:0] mvid;
        logic [6:0]  tu;
        logic [23:0] nvid;
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
        logic [8:0]  bs_cnt;
        logic        aud_pkt;
        logic [7:0]  msa_misc_a;
        logic [7:0]  msa_misc_b;
        logic [23:0] msa_mvid;
        logic [23:0] msa_nvid;
    } sar_state_t;

    typedef struct packed
    {
        logic        sync1;
        logic        sync2;
        logic        sync3;
        logic [23:0] win_cnt;
        logic [23:0] vid_cnt;
        logic [23:0] mvid;
        logic        valid;
    } sar_calc_t;

endpackage

/* File: hdl/sar_mvid_calc.sv */
// Measures the video to link clock ratio for asynchronous clocking.
// Assumes vid_toggle_i flips once per video clock in a foreign domain, slower than half of clk_i.
`timescale 1ns/1ps
`include "sar_defines.svh"
module sar_mvid_calc
(
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        srst_i,
    // Control
    input  wire logic        enable_i,
    input  wire logic [23:0] nvid_i,
    // Video clock evidence
    input  wire logic        vid_toggle_i,
    // Result
    output logic      [23:0] mvid_o,
    output logic             valid_o
);
    import sar_pkg::*;

    sar_calc_t c_r;
    sar_calc_t c_nxt;
    logic      vid_edge;

    always_comb
    begin
        c_nxt       = c_r;
        c_nxt.sync1 = vid_toggle_i;
        c_nxt.sync2 = c_r.sync1;
        c_nxt.sync3 = c_r.sync2;
        vid_edge    = c_r.sync2 ^ c_r.sync3;
        if (!enable_i)
        begin
            c_nxt.win_cnt = 24'h000000;
            c_nxt.vid_cnt = 24'h000000;
            c_nxt.valid   = 1'b0;
        end
        else if (c_r.win_cnt >= nvid_i - 24'h000001)
        begin
            // Window of N link cycles closed: M is the video clocks seen in it
            c_nxt.mvid    = c_r.vid_cnt + {23'h000000, vid_edge};
            c_nxt.valid   = 1'b1;
            c_nxt.win_cnt = 24'h000000;
            c_nxt.vid_cnt = 24'h000000;
        end
        else
        begin
            c_nxt.win_cnt = c_r.win_cnt + 24'h000001;
            c_nxt.vid_cnt = c_r.vid_cnt + {23'h000000, vid_edge};
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            c_r <= '0;
        end
        else
        begin
            c_r <= c_nxt;
        end
    end

    assign mvid_o  = c_r.mvid;
    assign valid_o = c_r.valid;

endmodule

/* File: hdl/sar_stream_attr_regs.sv */
// Stream attribute register bank with APB slave, frame attribute snapshot and audio-only packet pacing.
// Assumes an APB master on clk_i, and frame and BS symbol strobes from framing logic on the same clock.
`timescale 1ns/1ps
`include "sar_defines.svh"
module sar_stream_attr_regs
#(
    parameter logic [23:0] ASYNC_NVID = `SAR_ASYNC_NVID
)
(
    // Clock and reset
    input  wire logic                     clk_i,
    input  wire logic                     srst_i,
    // APB slave
    input  wire logic                     psel_i,
    input  wire logic                     penable_i,
    input  wire logic                     pwrite_i,
    input  wire logic [`SAR_ADDR_W-1:0]   paddr_i,
    input  wire logic [31:0]              pwdata_i,
    input  wire logic [3:0]               pstrb_i,
    output logic      [31:0]              prdata_o,
    output logic                          pready_o,
    output logic                          pslverr_o,
    // Framing logic strobes
    input  wire logic                     frame_start_i,
    input  wire logic                     bs_symbol_i,
    // Video clock evidence from a foreign domain
    input  wire logic                     vid_toggle_i,
    // Attribute register A fields
    output logic                          sync_clk_o,
    output logic      [1:0]               comp_format_o,
    output logic                          dyn_range_o,
    output logic                          colorimetry_o,
    output logic      [2:0]               bit_depth_o,
    output logic                          aud_clk_override_o,
    output logic                          aud_sync_mode_o,
    output logic                          audio_only_o,
    output logic                          aud_ratio_ctrl_o,
    // Attribute register B fields
    output logic                          vtotal_even_o,
    output logic      [1:0]               stereo_attr_o,
    // Framing control
    output logic      [6:0]               tu_size_o,
    output logic                          aud_pkt_insert_o,
    // Per-frame stream attribute data
    output logic      [7:0]               msa_misc_a_o,
    output logic      [7:0]               msa_misc_b_o,
    output logic      [23:0]              msa_mvid_o,
    output logic      [23:0]              msa_nvid_o
);
    import sar_pkg::*;

    sar_state_t  s_r;
    sar_state_t  s_nxt;
    sar_sel_t    sel;
    logic [31:0] rdata;
    logic [31:0] wmerge;
    logic        async_mode;
    logic [23:0] calc_mvid;
    logic        calc_valid;
    logic        access;
    logic        commit;

    // Address decode shared by read and write paths
    function automatic sar_sel_t decode(input logic [`SAR_ADDR_W-1:0] addr);
        sar_sel_t res;
        res = SAR_SEL_NONE;
        case (addr)
            `SAR_OFF_MISC_A: res = SAR_SEL_MISC_A;
            `SAR_OFF_MISC_B: res = SAR_SEL_MISC_B;
            `SAR_OFF_MVID:   res = SAR_SEL_MVID;
            `SAR_OFF_TU:     res = SAR_SEL_TU;
            `SAR_OFF_NVID:   res = SAR_SEL_NVID;
            `SAR_OFF_STATUS: res = SAR_SEL_STATUS;
            default:         res = SAR_SEL_NONE;
        endcase
        return res;
    endfunction

    // Byte lane merge of write data into a stored word
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] strb);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++)
        begin
            if (strb[i])
            begin
                res[i*8 +: 8] = wd[i*8 +: 8];
            end
        end
        return res;
    endfunction

    assign async_mode = ~s_r.misc_a[`SAR_MA_SYNC];

    // Ratio measurement for asynchronous clocking
    sar_mvid_calc u_mvid_calc
    (
        .clk_i        (clk_i),
        .srst_i       (srst_i),
        .enable_i     (async_mode),
        .nvid_i       (ASYNC_NVID),
        .vid_toggle_i (vid_toggle_i),
        .mvid_o       (calc_mvid),
        .valid_o      (calc_valid)
    );

    assign sel    = decode(paddr_i);
    assign access = psel_i & penable_i & ~s_r.pready;
    assign commit = psel_i & penable_i & s_r.pready;

    // Read multiplexer; computed ratio values never appear here
    always_comb
    begin
        rdata = 32'h00000000;
        case (sel)
            SAR_SEL_MISC_A: rdata = {20'h00000, s_r.misc_a};
            SAR_SEL_MISC_B: rdata = {24'h000000, s_r.misc_b};
            SAR_SEL_MVID:   rdata = {8'h00, s_r.mvid};
            SAR_SEL_TU:     rdata = {25'h0000000, s_r.tu};
            SAR_SEL_NVID:   rdata = {8'h00, s_r.nvid};
            SAR_SEL_STATUS: rdata = {7'h00, s_r.bs_cnt, 14'h0000, calc_valid, async_mode};
            default:        rdata = 32'h00000000;
        endcase
    end

    assign wmerge = merge(rdata, pwdata_i, pstrb_i);

    always_comb
    begin
        s_nxt         = s_r;
        s_nxt.pready  = 1'b0;
        s_nxt.pslverr = 1'b0;
        s_nxt.aud_pkt = 1'b0;

        // First access cycle prepares the answer, second one completes it
        if (access)
        begin
            s_nxt.pready  = 1'b1;
            s_nxt.pslverr = (sel == SAR_SEL_NONE);
            s_nxt.prdata  = pwrite_i ? 32'h00000000 : rdata;
        end

        // Writes take effect at the edge where pready is sampled high
        if (commit && pwrite_i)
        begin
            case (sel)
                SAR_SEL_MISC_A: s_nxt.misc_a = wmerge[11:0];
                SAR_SEL_MISC_B: s_nxt.misc_b = wmerge[7:0] & ~`SAR_MB_RSVD_MASK;
                SAR_SEL_MVID:   s_nxt.mvid   = wmerge[23:0];
                SAR_SEL_TU:     s_nxt.tu     = {wmerge[6:1], 1'b0};
                SAR_SEL_NVID:   s_nxt.nvid   = wmerge[23:0];
                default:        s_nxt.misc_a = s_r.misc_a;
            endcase
        end

        // Audio-only packet pacing over BS symbols
        if (!s_r.misc_a[`SAR_MA_AUD_ONLY])
        begin
            s_nxt.bs_cnt = 9'h000;
        end
        else if (bs_symbol_i)
        begin
            if (s_r.bs_cnt == `SAR_BS_CNT_LAST)
            begin
                s_nxt.bs_cnt  = 9'h000;
                s_nxt.aud_pkt = 1'b1;
            end
            else
            begin
                s_nxt.bs_cnt = s_r.bs_cnt + 9'h001;
            end
        end

        // Per-frame attribute snapshot
        if (frame_start_i)
        begin
            s_nxt.msa_misc_a = s_r.misc_a[7:0];
            s_nxt.msa_misc_b = s_r.misc_b;
            s_nxt.msa_mvid   = async_mode ? calc_mvid : s_r.mvid;
            s_nxt.msa_nvid   = async_mode ? ASYNC_NVID : s_r.nvid;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            s_r        <= '0;
            s_r.misc_a <= `SAR_MISC_A_RST;
            s_r.misc_b <= `SAR_MISC_B_RST;
            s_r.mvid   <= `SAR_RATIO_RST;
            s_r.nvid   <= `SAR_RATIO_RST;
            s_r.tu     <= `SAR_TU_RST;
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    // Outputs straight from the state register
    assign prdata_o           = s_r.prdata;
    assign pready_o           = s_r.pready;
    assign pslverr_o          = s_r.pslverr;
    assign sync_clk_o         = s_r.misc_a[`SAR_MA_SYNC];
    assign comp_format_o      = s_r.misc_a[`SAR_MA_FMT_HI:`SAR_MA_FMT_LO];
    assign dyn_range_o        = s_r.misc_a[`SAR_MA_RANGE];
    assign colorimetry_o      = s_r.misc_a[`SAR_MA_COLOR];
    assign bit_depth_o        = s_r.misc_a[`SAR_MA_DEPTH_HI:`SAR_MA_DEPTH_LO];
    assign aud_clk_override_o = s_r.misc_a[`SAR_MA_AUD_OVR];
    assign aud_sync_mode_o    = s_r.misc_a[`SAR_MA_AUD_SYNC];
    assign audio_only_o       = s_r.misc_a[`SAR_MA_AUD_ONLY];
    assign aud_ratio_ctrl_o   = s_r.misc_a[`SAR_MA_AUD_RATIO];
    assign vtotal_even_o      = s_r.misc_b[`SAR_MB_VT_EVEN];
    assign stereo_attr_o      = s_r.misc_b[`SAR_MB_STEREO_HI:`SAR_MB_STEREO_LO];
    assign tu_size_o          = s_r.tu;
    assign aud_pkt_insert_o   = s_r.aud_pkt;
    assign msa_misc_a_o       = s_r.msa_misc_a;
    assign msa_misc_b_o       = s_r.msa_misc_b;
    assign msa_mvid_o         = s_r.msa_mvid;
    assign msa_nvid_o         = s_r.msa_nvid;

endmodule

/* File: verif/sar_chk.sv */
// Concurrent checks on the stream attribute register ports.
// Assumes one clock and a bind into sar_stream_attr_regs.
`timescale 1ns/1ps
`include "sar_defines.svh"
module sar_chk
#(
    parameter logic [23:0] ASYNC_NVID = `SAR_ASYNC_NVID
)
(
    input wire logic        clk_i,
    input wire logic        srst_i,
    input wire logic        psel_i,
    input wire logic        penable_i,
    input wire logic        frame_start_i,
    input wire logic        bs_symbol_i,
    input wire logic        pready_o,
    input wire logic        pslverr_o,
    input wire logic        sync_clk_o,
    input wire logic [1:0]  comp_format_o,
    input wire logic        dyn_range_o,
    input wire logic        colorimetry_o,
    input wire logic [2:0]  bit_depth_o,
    input wire logic        vtotal_even_o,
    input wire logic [1:0]  stereo_attr_o,
    input wire logic [6:0]  tu_size_o,
    input wire logic        aud_pkt_insert_o,
    input wire logic [7:0]  msa_misc_a_o,
    input wire logic [7:0]  msa_misc_b_o,
    input wire logic [23:0] msa_nvid_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (srst_i);
    sequence s_frame; frame_start_i; endsequence
    sequence s_frame_async; frame_start_i && !sync_clk_o; endsequence
    property p_tu_rst; $fell(srst_i) |-> tu_size_o == `SAR_TU_RST; endproperty
    property p_tu_even; tu_size_o[0] == 1'b0; endproperty
    property p_msa_a;
        s_frame |=> msa_misc_a_o == $past({bit_depth_o, colorimetry_o, dyn_range_o, comp_format_o, sync_clk_o});
    endproperty
    property p_msa_b; s_frame |=> msa_misc_b_o[2:0] == $past({stereo_attr_o, vtotal_even_o}); endproperty
    property p_msa_hold; !frame_start_i |=> $stable(msa_misc_a_o) && $stable(msa_misc_b_o); endproperty
    property p_async_n; s_frame_async |=> msa_nvid_o == ASYNC_NVID; endproperty
    property p_pkt; aud_pkt_insert_o |-> $past(bs_symbol_i) ##1 !aud_pkt_insert_o; endproperty
    property p_ready; pready_o |-> psel_i && penable_i ##1 !pready_o; endproperty
    property p_err; pslverr_o |-> pready_o; endproperty
    a_tu_rst: assert property (p_tu_rst) else $error("transfer unit reset value wrong");
    a_tu_even: assert property (p_tu_even) else $error("transfer unit size odd");
    a_msa_a: assert property (p_msa_a) else $error("frame attribute A byte wrong");
    a_msa_b: assert property (p_msa_b) else $error("frame attribute B byte wrong");
    a_msa_hold: assert property (p_msa_hold) else $error("frame attributes moved between frames");
    a_async_n: assert property (p_async_n) else $error("async N value wrong");
    a_pkt: assert property (p_pkt) else $error("packet insert pulse wrong");
    a_ready: assert property (p_ready) else $error("pready outside access phase");
    a_err: assert property (p_err) else $error("pslverr without pready");
endmodule

bind sar_stream_attr_regs sar_chk #(.ASYNC_NVID(ASYNC_NVID)) u_chk
(
    .clk_i            (clk_i),
    .srst_i           (srst_i),
    .psel_i           (psel_i),
    .penable_i        (penable_i),
    .frame_start_i    (frame_start_i),
    .bs_symbol_i      (bs_symbol_i),
    .pready_o         (pready_o),
    .pslverr_o        (pslverr_o),
    .sync_clk_o       (sync_clk_o),
    .comp_format_o    (comp_format_o),
    .dyn_range_o      (dyn_range_o),
    .colorimetry_o    (colorimetry_o),
    .bit_depth_o      (bit_depth_o),
    .vtotal_even_o    (vtotal_even_o),
    .stereo_attr_o    (stereo_attr_o),
    .tu_size_o        (tu_size_o),
    .aud_pkt_insert_o (aud_pkt_insert_o),
    .msa_misc_a_o     (msa_misc_a_o),
    .msa_misc_b_o     (msa_misc_b_o),
    .msa_nvid_o       (msa_nvid_o)
);

/* File: verif/sar_stream_attr_regs_tb.sv */
// Self-checking bench for the stream attribute registers, APB master in the bench.
// Assumes sar_defines.svh on the include path and sar_chk bound into the block.
`timescale 1ns/1ps
`include "sar_defines.svh"
module sar_stream_attr_regs_tb;
    localparam logic [23:0] NV = 24'h000010;
    logic        clk_i, srst_i, psel, penable, pwrite, frame, bs, vid, e;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, r;
    logic        pready, perr, sclk, dr, col, aovr, asyn, aonly, arat, vte, pkt;
    logic [1:0]  cf, st;
    logic [2:0]  bd;
    logic [6:0]  tu;
    logic [7:0]  ma, mb;
    logic [23:0] mm, mn;
    int          bad_count = 0, n_compared = 0, pulses = 0;

    sar_stream_attr_regs #(.ASYNC_NVID(NV)) dut
    (
        .clk_i(clk_i), .srst_i(srst_i), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
        .paddr_i(paddr), .pwdata_i(pwdata), .pstrb_i(4'hf), .prdata_o(prdata), .pready_o(pready),
        .pslverr_o(perr), .frame_start_i(frame), .bs_symbol_i(bs), .vid_toggle_i(vid),
        .sync_clk_o(sclk), .comp_format_o(cf), .dyn_range_o(dr), .colorimetry_o(col), .bit_depth_o(bd),
        .aud_clk_override_o(aovr), .aud_sync_mode_o(asyn), .audio_only_o(aonly), .aud_ratio_ctrl_o(arat),
        .vtotal_even_o(vte), .stereo_attr_o(st), .tu_size_o(tu), .aud_pkt_insert_o(pkt),
        .msa_misc_a_o(ma), .msa_misc_b_o(mb), .msa_mvid_o(mm), .msa_nvid_o(mn)
    );

    initial
    begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end

    always @(negedge clk_i)
        if (pkt === 1'b1)
            pulses++;

    task automatic give_verdict;
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk_i);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_i);
        penable <= 1'b1;
        // Sample pready, data and error at the rising edge that completes the transfer
        do
        begin
            @(posedge clk_i);
        end
        while (pready !== 1'b1);
        r = prdata;
        e = perr;
        psel <= 1'b0;
        penable <= 1'b0;
        // Let the committed write settle on the outputs before anyone looks
        @(negedge clk_i);
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] x, input string nm);
        apb(1'b0, a, 32'h0);
        chk(nm, r, x);
        chk({nm, "_err"}, e, 32'h0);
    endtask

    task automatic frm;
        @(posedge clk_i) frame <= 1'b1;
        @(posedge clk_i) frame <= 1'b0;
        @(negedge clk_i);
    endtask

    task automatic t_reset;
        rd(`SAR_OFF_MISC_A, 32'h0, "misc_a");
        rd(`SAR_OFF_TU, 32'h40, "tu");
        chk("tu_out", tu, 32'h40);
        chk("audio_only", aonly, 32'h0);
    endtask

    task automatic t_attr;
        logic [11:0] v [2];
        v = '{12'ha5b, 12'h5a4};
        for (int i = 0; i < 2; i++)
        begin
            apb(1'b1, `SAR_OFF_MISC_A, v[i]);
            chk("a_fields", {arat, aonly, asyn, aovr, bd, col, dr, cf, sclk}, v[i]);
            rd(`SAR_OFF_MISC_A, v[i], "misc_a");
        end
        apb(1'b1, `SAR_OFF_MISC_B, 32'hff);
        rd(`SAR_OFF_MISC_B, 32'h87, "misc_b");
        chk("b_fields", {st, vte}, 32'h7);
    endtask

    task automatic t_ratio;
        apb(1'b1, `SAR_OFF_MISC_A, 32'h1);
        apb(1'b1, `SAR_OFF_MVID, 32'hff123456);
        apb(1'b1, `SAR_OFF_NVID, 32'hff654321);
        rd(`SAR_OFF_MVID, 32'h123456, "m_reg");
        rd(`SAR_OFF_NVID, 32'h654321, "n_reg");
        frm();
        chk("msa_m", mm, 32'h123456);
        chk("msa_n", mn, 32'h654321);
        chk("msa_a", ma, 32'h01);
        chk("msa_b", {mb[7], mb[2:0]}, 32'hf);
    endtask

    task automatic t_async;
        apb(1'b1, `SAR_OFF_MISC_A, 32'h0);
        repeat (100)
        begin
            @(posedge clk_i) vid <= ~vid;
            repeat (2) @(posedge clk_i);
        end
        frm();
        chk("msa_n_async", mn, NV);
        chk("msa_m_async", 32'(mm >= 24'h000005 && mm <= 24'h000006), 32'h1);
        rd(`SAR_OFF_STATUS, 32'h3, "status");
        rd(`SAR_OFF_MVID, 32'h123456, "m_async");
        rd(`SAR_OFF_NVID, 32'h654321, "n_async");
    endtask

    task automatic t_tu;
        apb(1'b1, `SAR_OFF_TU, 32'h21);
        rd(`SAR_OFF_TU, 32'h20, "tu_odd");
        chk("tu_out", tu, 32'h20);
        apb(1'b1, `SAR_OFF_TU, 32'h3f);
        rd(`SAR_OFF_TU, 32'h3e, "tu_max");
    endtask

    task automatic t_audio;
        apb(1'b1, `SAR_OFF_MISC_A, 32'h400);
        pulses = 0;
        repeat (511) @(posedge clk_i) bs <= 1'b1;
        @(posedge clk_i) bs <= 1'b0;
        repeat (3) @(negedge clk_i);
        chk("pkt_early", pulses, 32'h0);
        @(posedge clk_i) bs <= 1'b1;
        @(posedge clk_i) bs <= 1'b0;
        repeat (3) @(negedge clk_i);
        chk("pkt_512", pulses, 32'h1);
        apb(1'b1, `SAR_OFF_MISC_A, 32'h0);
    endtask

    task automatic t_unmapped;
        rd(`SAR_OFF_TU, 32'h3e, "tu_pre");
        apb(1'b0, 12'h1fc, 32'h0);
        chk("err_rd", e, 32'h1);
        chk("data_rd", r, 32'h0);
        apb(1'b1, 12'h1fc, 32'hffffffff);
        chk("err_wr", e, 32'h1);
        rd(`SAR_OFF_TU, 32'h3e, "tu_kept");
    endtask

    initial
    begin
        srst_i = 1'b1;
        {psel, penable, pwrite, frame, bs, vid} = 6'h0;
        paddr = 12'h0;
        pwdata = 32'h0;
        repeat (8) @(posedge clk_i);
        srst_i <= 1'b0;
        t_reset();
        t_attr();
        t_ratio();
        t_async();
        t_tu();
        t_audio();
        t_unmapped();
        give_verdict();
    end

    initial
    begin
        repeat (20000) @(posedge clk_i);
        bad_count++;
        give_verdict();
    end
endmodule
